/* File: hw/idec_core.sv */
`timescale 1ns/1ps
`default_nettype none

module idec_core
    import idec_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [WORD_W-1:0] prog_word,
    input  wire logic              cond_true,
    input  wire logic [PC_W-1:0]   alt_target,
    input  wire logic              ext_en,
    output logic [PC_W-1:0]        fetch_addr_ff,
    output logic [Q_W-1:0]         q_ff,
    output var idec_exec_t         exec_ff
);

    function automatic idec_dec_t decode(input logic [WORD_W-1:0] w, input logic xe);
        idec_dec_t r;
        r = '0;
        r.cls = cls_bad;
        r.flow = flw_none;
        r.dest = w[DEST_POS];
        r.access = w[ACC_POS];
        r.f8 = w[F8_W-1:0];
        r.f12 = w[F12_W-1:0];
        r.bitn = w[BITN_LSB +: BITN_W];
        r.lit = w[LIT_W-1:0];
        r.fast = w[FAST_RET_POS];
        r.tmode = w[TMODE_W-1:0];
        r.off = {{(OFF_W-LIT_W){w[LIT_W-1]}}, w[LIT_W-1:0]};
        // first match wins, so narrow patterns sit above the wide ones
        casez (w)
            16'b0000_0000_0000_0000,
            16'b0000_0000_0000_0011,
            16'b0000_0000_0000_01??,
            16'b0000_0000_1111_1111,
            16'b0000_0000_0000_1???: r.cls = cls_ctl;
            16'b0000_0000_0001_00??: begin
                r.cls = cls_ctl;
                r.flow = flw_alt;
            end
            16'b0000_0000_0001_0100: begin
                r.cls = cls_ctl;
                r.flow = flw_alt;
                r.ext = 1'b1;
            end
            16'b0000_0001_0000_????: r.cls = cls_lit;
            16'b0000_0001_????_????: r.cls = cls_bad;
            16'b0000_001?_????_????,
            16'b0000_01??_????_????: r.cls = cls_byte;
            16'b0000_1100_????_????: begin
                r.cls = cls_lit;
                r.flow = flw_alt;
            end
            16'b0000_1???_????_????: r.cls = cls_lit;
            16'b0000_????_????_????: r.cls = cls_bad;
            16'b0010_11??_????_????,
            16'b0011_11??_????_????,
            16'b0100_1???_????_????,
            16'b0110_0???_????_????: begin
                r.cls = cls_byte;
                r.flow = flw_skip;
            end
            16'b0001_????_????_????,
            16'b001?_????_????_????,
            16'b010?_????_????_????,
            16'b0110_1???_????_????: r.cls = cls_byte;
            16'b0111_????_????_????,
            16'b100?_????_????_????: r.cls = cls_bit;
            16'b101?_????_????_????: begin
                r.cls = cls_bit;
                r.flow = flw_skip;
            end
            16'b1100_????_????_????: begin
                r.cls = cls_byte;
                r.dbl = 1'b1;
            end
            16'b1101_????_????_????: begin
                r.cls = cls_ctl;
                r.flow = flw_rel;
                r.off = w[OFF_W-1:0];
            end
            16'b1110_0???_????_????: begin
                r.cls = cls_ctl;
                r.flow = flw_bcc;
            end
            16'b1110_100?_????_????: begin
                r.cls = cls_lit;
                r.ext = 1'b1;
                r.ptr = w[PTR_ADD_LSB +: PTR_W];
                if (r.ptr == PTR_ULNK) begin
                    r.flow = flw_alt;
                end
            end
            16'b1110_1010_????_????: begin
                r.cls = cls_lit;
                r.ext = 1'b1;
            end
            16'b1110_1011_????_????: begin
                r.cls = cls_byte;
                r.ext = 1'b1;
                r.dbl = 1'b1;
            end
            16'b1110_110?_????_????: begin
                r.cls = cls_ctl;
                r.flow = flw_abs;
                r.dbl = 1'b1;
                r.fast = w[FAST_CALL_POS];
            end
            16'b1110_1110_00??_????: begin
                r.cls = cls_lit;
                r.dbl = 1'b1;
                r.ptr = w[PTR_LFSR_LSB +: PTR_W];
            end
            16'b1110_1111_????_????: begin
                r.cls = cls_ctl;
                r.flow = flw_abs;
                r.dbl = 1'b1;
            end
            16'b1111_????_????_????: r.cls = cls_word2;
            default: r.cls = cls_bad;
        endcase
        // extended opcodes fall back to no-ops while the extension is off
        if (r.ext && !xe) begin
            r.cls = cls_bad;
            r.flow = flw_none;
            r.dbl = 1'b0;
        end
        return r;
    endfunction

    function automatic logic [PC_W-1:0] rel_target(input logic [PC_W-1:0] base,
                                                   input logic [OFF_W-1:0] off);
        return base + {{(PC_W-OFF_W-1){off[OFF_W-1]}}, off, 1'b0};
    endfunction

    logic                 ext_meta_ff;
    logic                 ext_sync_ff;
    idec_state_t          st_ff;
    idec_state_t          nxt_st;
    idec_exec_t           nxt_exec;
    idec_dec_t            dec_in;
    logic [PC_W-1:0]      nxt_fetch;
    logic [PC_W-1:0]      abs_tgt;
    logic                 icyc_end;
    logic                 live;

    // configuration pin comes from outside the clock domain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
        end else begin
            ext_meta_ff <= ext_en;
            ext_sync_ff <= ext_meta_ff;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q_ff <= Q_FIRST;
        end else if (q_ff == Q_LAST) begin
            q_ff <= Q_FIRST;
        end else begin
            q_ff <= q_ff + Q_ONE;
        end
    end

    assign icyc_end = (q_ff == Q_LAST);
    assign abs_tgt = {prog_word[F12_W-1:0], exec_ff.d.lit, 1'b0};

    always_comb begin
        live = (st_ff == st_exec) && !exec_ff.nop;
        dec_in = decode(prog_word, ext_sync_ff);
        nxt_st = st_exec;
        nxt_fetch = fetch_addr_ff + PC_STEP;
        nxt_exec = '0;
        nxt_exec.d = dec_in;
        nxt_exec.pc = fetch_addr_ff;
        nxt_exec.nop = (dec_in.cls == cls_word2) || (dec_in.cls == cls_bad);
        if (live) begin
            unique case (exec_ff.d.flow)
                flw_skip: begin
                    if (cond_true) begin
                        nxt_st = st_flush;
                    end
                end
                flw_bcc: begin
                    if (cond_true) begin
                        nxt_st = st_flush;
                        nxt_fetch = rel_target(fetch_addr_ff, exec_ff.d.off);
                    end
                end
                flw_rel: begin
                    nxt_st = st_flush;
                    nxt_fetch = rel_target(fetch_addr_ff, exec_ff.d.off);
                end
                flw_alt: begin
                    nxt_st = st_flush;
                    nxt_fetch = alt_target;
                end
                default: begin
                end
            endcase
            // the second word rides in the slot after the first; target is known
            // early enough that call/goto need no flush cycle
            if (exec_ff.d.dbl) begin
                nxt_st = st_word2;
                nxt_exec = exec_ff;
                nxt_exec.slot2 = 1'b1;
                nxt_exec.w2 = prog_word[F12_W-1:0];
                if (exec_ff.d.flow == flw_abs) begin
                    nxt_exec.target = abs_tgt;
                    nxt_fetch = abs_tgt;
                end
            end
        end
        // a discarded word that opens a double-word leaves its second word to
        // run alone as a nop, giving the three-cycle skip
        if (nxt_st == st_flush) begin
            nxt_exec.nop = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_ff <= st_flush;
        end else if (icyc_end) begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            exec_ff <= '0;
            exec_ff.nop <= 1'b1;
        end else if (icyc_end) begin
            exec_ff <= nxt_exec;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fetch_addr_ff <= PC_RST;
        end else if (icyc_end) begin
            fetch_addr_ff <= nxt_fetch;
        end
    end

endmodule // idec_core

`default_nettype wire

/* File: hw/idec_pkg.sv */
package idec_pkg;

    localparam int OSC_PER_ICYC = 4;
    localparam int Q_W = 2;
    localparam logic [Q_W-1:0] Q_FIRST = 2'h0;
    localparam logic [Q_W-1:0] Q_ONE = 2'h1;
    localparam logic [Q_W-1:0] Q_LAST = Q_W'(OSC_PER_ICYC - 1);

    localparam int WORD_W = 16;
    localparam int PC_W = 21;
    localparam logic [PC_W-1:0] PC_RST = 21'h0_0000;
    localparam logic [PC_W-1:0] PC_STEP = 21'h0_0002;

    localparam int WORD2_LSB = 12;
    localparam logic [3:0] WORD2_MARK = 4'hF;
    localparam int F12_W = 12;
    localparam int F8_W = 8;
    localparam int LIT_W = 8;
    localparam int OFF_W = 11;
    localparam int DEST_POS = 9;
    localparam int ACC_POS = 8;
    localparam int BITN_LSB = 9;
    localparam int BITN_W = 3;
    localparam int FAST_CALL_POS = 8;
    localparam int FAST_RET_POS = 0;
    localparam int TMODE_W = 2;
    localparam int PTR_W = 2;
    localparam int PTR_LFSR_LSB = 4;
    localparam int PTR_ADD_LSB = 6;
    localparam logic [PTR_W-1:0] PTR_ULNK = 2'h3;

    typedef enum logic [2:0] {
        cls_byte,
        cls_bit,
        cls_lit,
        cls_ctl,
        cls_word2,
        cls_bad
    } idec_cls_t;

    typedef enum logic [2:0] {
        flw_none,
        flw_skip,
        flw_bcc,
        flw_rel,
        flw_abs,
        flw_alt
    } idec_flow_t;

    typedef enum logic [1:0] {
        st_exec,
        st_word2,
        st_flush
    } idec_state_t;

    typedef struct packed {
        idec_cls_t            cls;
        idec_flow_t           flow;
        logic                 dbl;
        logic                 ext;
        logic                 dest;
        logic                 access;
        logic [F8_W-1:0]      f8;
        logic [F12_W-1:0]     f12;
        logic [BITN_W-1:0]    bitn;
        logic [LIT_W-1:0]     lit;
        logic [PTR_W-1:0]     ptr;
        logic                 fast;
        logic [TMODE_W-1:0]   tmode;
        logic [OFF_W-1:0]     off;
    } idec_dec_t;

    typedef struct packed {
        idec_dec_t            d;
        logic                 slot2;
        logic                 nop;
        logic [F12_W-1:0]     w2;
        logic [PC_W-1:0]      target;
        logic [PC_W-1:0]      pc;
    } idec_exec_t;

endpackage

/* File: tb/idec_core_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module idec_core_properties
    import idec_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic [WORD_W-1:0] prog_word,
    input wire logic              cond_true,
    input wire logic [PC_W-1:0]   alt_target,
    input wire logic              ext_en,
    input wire logic [PC_W-1:0]   fetch_addr_ff,
    input wire logic [Q_W-1:0]    q_ff,
    input wire idec_exec_t        exec_ff
);
    wire logic            bnd;
    wire logic            live;
    wire logic            jmp;
    wire logic [PC_W-1:0] rel_tgt;
    assign bnd = (q_ff == Q_LAST);
    assign live = bnd && !exec_ff.nop;
    assign jmp = exec_ff.d.flow == flw_rel || (exec_ff.d.flow == flw_bcc && cond_true);
    // sign extension by hand so the offset doubles before the add
    assign rel_tgt = exec_ff.pc + PC_STEP + {{9{exec_ff.d.off[OFF_W-1]}}, exec_ff.d.off, 1'b0};
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    AST_Q_STEP: assert property (q_ff == Q_LAST |=> q_ff == Q_FIRST ##1 q_ff == Q_ONE)
        else $error("phase did not wrap to zero");
    AST_HOLD: assert property (!bnd |=> $stable(exec_ff) && $stable(fetch_addr_ff))
        else $error("slot changed inside an instruction cycle");
    AST_SLOT2: assert property (live && exec_ff.d.dbl && !exec_ff.slot2 |=>
        exec_ff.slot2 && exec_ff.w2 == $past(prog_word[F12_W-1:0]))
        else $error("second word not taken after first");
    AST_DBL_TWO: assert property (bnd && exec_ff.slot2 |=> !exec_ff.slot2)
        else $error("double word longer than two cycles");
    AST_ORPHAN: assert property (bnd && prog_word[15:12] == WORD2_MARK &&
        !(!exec_ff.nop && exec_ff.d.dbl && !exec_ff.slot2) |=> exec_ff.nop)
        else $error("lone second word not a nop");
    AST_SEQ_FETCH: assert property (live && exec_ff.d.flow == flw_none |=>
        fetch_addr_ff == $past(fetch_addr_ff) + PC_STEP)
        else $error("sequential fetch did not step by two");
    AST_REL_TGT: assert property (live && jmp |=> fetch_addr_ff == $past(rel_tgt))
        else $error("relative branch target wrong");
    AST_FLUSH: assert property (live && (jmp || (exec_ff.d.flow == flw_skip && cond_true))
        |=> exec_ff.nop)
        else $error("slot after taken flow not a nop");
    AST_ABS_TGT: assert property (exec_ff.slot2 && exec_ff.d.flow == flw_abs |->
        exec_ff.target == {exec_ff.w2, exec_ff.d.lit, 1'b0})
        else $error("absolute target wrong");
    COV_SKIP: cover property (live && exec_ff.d.flow == flw_skip && cond_true);
    COV_SLOT2: cover property (bnd && exec_ff.slot2);
    COV_BCC: cover property (live && exec_ff.d.flow == flw_bcc && cond_true);
endmodule // idec_core_properties
bind idec_core idec_core_properties u_props (.clk(clk), .rst(rst), .prog_word(prog_word),
    .cond_true(cond_true), .alt_target(alt_target), .ext_en(ext_en),
    .fetch_addr_ff(fetch_addr_ff), .q_ff(q_ff), .exec_ff(exec_ff));
`default_nettype wire

/* File: tb/test_mcu_instruction_decoder.sv */
`timescale 1ns/1ps
`default_nettype none
module test_mcu_instruction_decoder import idec_pkg::*;;
    localparam logic [PC_W-1:0] DC = 21'h1F_FFFF;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [WORD_W-1:0] prog_word = 16'h0000;
    logic              cond_true = 1'b0;
    logic [PC_W-1:0]   alt_target = 21'h0_0000;
    logic              ext_en = 1'b0;
    logic              ext_req = 1'b0;
    logic [PC_W-1:0]   fetch_addr_ff;
    logic [Q_W-1:0]    q_ff;
    idec_exec_t        exec_ff;
    logic [WORD_W-1:0] mem [0:31];
    int                failures = 0;
    int                num_checks = 0;
    int                cycles = 0;
    idec_core uut (.clk(clk), .rst(rst), .prog_word(prog_word), .cond_true(cond_true),
        .alt_target(alt_target), .ext_en(ext_en), .fetch_addr_ff(fetch_addr_ff),
        .q_ff(q_ff), .exec_ff(exec_ff));
    initial begin
        forever #12.5 clk = ~clk;
    end
    // program memory answers the fetch address, settled long before the boundary
    always @(posedge clk) begin
        prog_word <= mem[fetch_addr_ff[5:1]];
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1000) begin
            failures = failures + 1;
            end_of_test();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // called just after a boundary; checks the slot then lets one instruction cycle run
    task automatic step(input logic [PC_W-1:0] pc, input logic nop, input logic s2,
                        input logic c);
        chk("phase", q_ff, 32'h0000_0000);
        chk("nop", exec_ff.nop, nop);
        chk("slot2", exec_ff.slot2, s2);
        if (pc !== DC) chk("pc", exec_ff.pc, pc);
        @(posedge clk);
        cond_true <= c;
        ext_en <= ext_req;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        #1;
        chk("rst phase", q_ff, 32'h0000_0000);
        chk("rst fetch", fetch_addr_ff, PC_RST);
        chk("rst nop", exec_ff.nop, 1'b1);
        @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic t_single;
        chk("cls", exec_ff.d.cls, cls_byte);
        chk("dest", exec_ff.d.dest, 1'b1);
        chk("access", exec_ff.d.access, 1'b0);
        chk("f8", exec_ff.d.f8, 8'h25);
        step(21'h0_0000, 1'b0, 1'b0, 1'b0);
        chk("dest", exec_ff.d.dest, 1'b0);
        chk("access", exec_ff.d.access, 1'b1);
        chk("f8", exec_ff.d.f8, 8'h3C);
        step(21'h0_0002, 1'b0, 1'b0, 1'b0);
        chk("cls", exec_ff.d.cls, cls_bit);
        chk("bitn", exec_ff.d.bitn, 3'h5);
        chk("f8", exec_ff.d.f8, 8'h12);
        step(21'h0_0004, 1'b0, 1'b0, 1'b0);
        chk("cls", exec_ff.d.cls, cls_lit);
        chk("lit", exec_ff.d.lit, 8'h7F);
        step(21'h0_0006, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic t_double;
        chk("dbl", exec_ff.d.dbl, 1'b1);
        chk("f12", exec_ff.d.f12, 12'h123);
        step(21'h0_0008, 1'b0, 1'b0, 1'b0);
        chk("w2", exec_ff.w2, 12'h456);
        step(21'h0_0008, 1'b0, 1'b1, 1'b0);
        chk("cls", exec_ff.d.cls, cls_word2);
        step(21'h0_000C, 1'b1, 1'b0, 1'b0);
    endtask
    // skip over a double word: flushed first word, then the lone second word
    task automatic t_skip;
        step(21'h0_000E, 1'b0, 1'b0, 1'b1);
        step(DC, 1'b1, 1'b0, 1'b0);
        chk("cls", exec_ff.d.cls, cls_word2);
        step(DC, 1'b1, 1'b0, 1'b0);
    endtask
    task automatic t_branch;
        step(21'h0_0014, 1'b0, 1'b0, 1'b1);
        step(DC, 1'b1, 1'b0, 1'b0);
        chk("dbl", exec_ff.d.dbl, 1'b1);
        step(21'h0_0018, 1'b0, 1'b0, 1'b0);
        chk("target", exec_ff.target, 21'h0_0020);
        step(21'h0_0018, 1'b0, 1'b1, 1'b0);
        step(21'h0_0020, 1'b0, 1'b0, 1'b0);
    endtask
    // extended op refused while disabled, accepted on the next pass of the loop
    task automatic t_ext;
        chk("cls", exec_ff.d.cls, cls_bad);
        step(21'h0_0022, 1'b1, 1'b0, 1'b0);
        ext_req = 1'b1;
        step(21'h0_0024, 1'b0, 1'b0, 1'b0);
        step(DC, 1'b1, 1'b0, 1'b0);
        step(21'h0_0020, 1'b0, 1'b0, 1'b0);
        chk("ext", exec_ff.d.ext, 1'b1);
        chk("ptr", exec_ff.d.ptr, 2'h1);
        step(21'h0_0022, 1'b0, 1'b0, 1'b0);
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        mem = '{default: 16'h0000};
        mem[0] = 16'h2625;
        mem[1] = 16'h153C;
        mem[2] = 16'h8B12;
        mem[3] = 16'h0E7F;
        mem[4] = 16'hC123;
        mem[5] = 16'hF456;
        mem[6] = 16'hF0AB;
        mem[7] = 16'hB000;
        mem[8] = 16'hEF0C;
        mem[9] = 16'hF000;
        mem[10] = 16'hE201;
        mem[12] = 16'hEF10;
        mem[13] = 16'hF000;
        mem[16] = 16'hB000;
        mem[17] = 16'hE845;
        mem[18] = 16'hD7FD;
        t_reset();
        t_single();
        t_double();
        t_skip();
        t_branch();
        t_ext();
        t_reset();
        chk("cls", exec_ff.d.cls, cls_byte);
        step(21'h0_0000, 1'b0, 1'b0, 1'b0);
        end_of_test();
    end
endmodule // test_mcu_instruction_decoder
`default_nettype wire
